// ### src/gtm_pkg.sv
package gtm_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_TIMER = 4'h4;
  localparam logic [3:0] OFS_START = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // Operating mode field, bits 1:0 of the mode register.
  localparam int MODE_LSB = 0;
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;

  // Mode register fields.
  localparam int OUT_EN_BIT = 2;
  localparam int GATE_EN_BIT = 3;
  localparam int GATE_LVL_BIT = 4;
  localparam int DIR_PIN_BIT = 5;
  localparam int SRC_LSB = 6;
  localparam int EDGE_BIT = 6;
  localparam int PEER_BIT = 7;
  localparam int FREE_BIT = 8;
  localparam int UP_BIT = 9;
  localparam int MODE_W = 10;

  // Count-source selections for timer mode.
  localparam logic [1:0] SRC_DIV1 = 2'h0;
  localparam logic [1:0] SRC_DIV8 = 2'h1;
  localparam logic [1:0] SRC_DIV32 = 2'h2;
  localparam logic [1:0] SRC_SUB32 = 2'h3;

  // Prescaler ratios.
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1F;

  // Reset values and count limits.
  localparam logic [15:0] TIMER_RST = 16'hFFFF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_MIN = 16'h0000;
  localparam logic [MODE_W-1:0] MODE_RST = 10'h000;

  // Status register bits.
  localparam int ST_OUT_BIT = 0;
  localparam int ST_REQ_BIT = 1;

endpackage : gtm_pkg

// ### src/gtm_channel.sv
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/10ps
// Summary of operation
// - Mode field, bits 1:0, selects timer/event.
// - Timer source: clock, /8, /32, subclock/32.
// - Timer mode counts down, reloads on underflow.
// - Timer underflow period is n plus one.
// - Count-start flag runs or holds counter.
// - Timer mode underflow raises interrupt request.
// - Timer register read returns current count.
// - Write while stopped loads reload and counter.
// - Write while running loads reload only.
// - Gate option: input pin level gates counting.
// - Pulse output toggles on each timer underflow.
// - Event source: input pin edge or peer overflow.
// - Direction from software or output pin level.
// - Without free-run, over/underflow reloads counter.
// - Free-run: counter wraps without reloading.
// - Up-count period is FFFF minus n plus one.
// - Down-count period is n plus one events.
// - Event mode over/underflow raises interrupt request.
// - Pulse output toggles on event over/underflow.
// - Output pin: port, pulse output, or direction input.
module gtm_channel #(
  parameter int CHANNEL = 0
) (
  // System.
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Avalon-MM slave.
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Count sources from outside.
  input wire logic SUBCLOCK_TICK,
  input wire logic PEER_B_GROUP_TIMER_OVERFLOW,
  input wire logic NEIGHBOUR_CHANNEL_OVERFLOW,
  // Channel pins.
  input wire logic CHANNEL_EVENT_INPUT_PIN,
  input wire logic CHANNEL_TOGGLE_OUTPUT_PIN_I,
  output logic CHANNEL_TOGGLE_OUTPUT_PIN_O,
  output logic CHANNEL_TOGGLE_OUTPUT_PIN_OE,
  // Channel events.
  output logic IRQ_PULSE,
  output logic OVERFLOW_PULSE
);

  // Only channels zero to four exist; anything else is refused at elaboration.
  if (CHANNEL < 0 || CHANNEL > 4) begin : g_bad_channel
    $error("CHANNEL must lie in 0..4");
  end

  typedef struct packed {
    logic [gtm_pkg::MODE_W-1:0] mode;
    logic start;
    logic [15:0] reload;
    logic [15:0] count;
    logic tog;
    logic irq;
    logic ovf;
    logic [31:0] rdata;
    logic ack;
  } gtm_state_s;

  gtm_state_s s_q;
  gtm_state_s s_d;

  // Decoded mode bits.
  logic is_timer;
  logic is_event;
  logic [1:0] src_sel;
  logic tick;
  logic dir_up;
  logic wrap;
  logic gate_ok;
  logic in_edge;
  logic sub_edge;
  logic in_stable;
  logic dir_stable;
  logic sub_stable;
  logic access;
  logic [15:0] wr_val;
  logic in_level;
  logic in_prev;
  logic dir_level;
  logic sub_level;
  logic sub_prev;
  logic pre8_last;
  logic pre32_last;
  logic presub_last;

  assign is_timer = s_q.mode[1:0] == gtm_pkg::MODE_TIMER;
  assign is_event = s_q.mode[1:0] == gtm_pkg::MODE_EVENT;
  assign src_sel = s_q.mode[gtm_pkg::SRC_LSB +: 2];
  assign access = (AVS_READ || AVS_WRITE) && !s_q.ack;

  // Each channel pin and the subclock tick pass their own three-stage synchroniser; the peer overflow inputs go straight to the tick select.
  gtm_sync3 in_sync_u (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .pin(CHANNEL_EVENT_INPUT_PIN),
    .level(in_level),
    .stable(in_stable),
    .prev(in_prev)
  );
  gtm_sync3 dir_sync_u (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .pin(CHANNEL_TOGGLE_OUTPUT_PIN_I),
    .level(dir_level),
    .stable(dir_stable),
    .prev()
  );
  gtm_sync3 sub_sync_u (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .pin(SUBCLOCK_TICK),
    .level(sub_level),
    .stable(sub_stable),
    .prev(sub_prev)
  );

  // Prescalers run freely, so the first tick after a start is never early by more than one period.
  gtm_prescale #(.LAST(gtm_pkg::DIV8_LAST)) pre8_u (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .advance(1'b1),
    .at_last(pre8_last)
  );
  gtm_prescale #(.LAST(gtm_pkg::DIV32_LAST)) pre32_u (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .advance(1'b1),
    .at_last(pre32_last)
  );
  gtm_prescale #(.LAST(gtm_pkg::DIV32_LAST)) presub_u (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .advance(sub_edge),
    .at_last(presub_last)
  );

  // Edges count only on agreed levels, once per change.
  assign in_edge = in_stable && (in_level != in_prev) &&
                   (in_level == !s_q.mode[gtm_pkg::EDGE_BIT]);
  assign sub_edge = sub_stable && sub_level && !sub_prev;

  // The gate pin level must match the programmed active level while gating is on.
  assign gate_ok = !s_q.mode[gtm_pkg::GATE_EN_BIT] ||
                   (in_prev == s_q.mode[gtm_pkg::GATE_LVL_BIT]);

  // Count direction: software bit, or the output pin acting as select input.
  assign dir_up = is_event && (s_q.mode[gtm_pkg::DIR_PIN_BIT] ? dir_level
                                                                 : s_q.mode[gtm_pkg::UP_BIT]);

  // Pick one count tick per cycle for the selected source.
  always_comb begin
    tick = 1'b0;
    if (is_timer) begin
      unique case (src_sel)
        gtm_pkg::SRC_DIV1: tick = 1'b1;
        gtm_pkg::SRC_DIV8: tick = pre8_last;
        gtm_pkg::SRC_DIV32: tick = pre32_last;
        gtm_pkg::SRC_SUB32: tick = sub_edge && presub_last;
      endcase
      tick = tick && gate_ok;
    end else if (is_event) begin
      tick = s_q.mode[gtm_pkg::PEER_BIT] ? (CHANNEL == 0 ? PEER_B_GROUP_TIMER_OVERFLOW
                                                         : NEIGHBOUR_CHANNEL_OVERFLOW)
                                         : in_edge;
    end
    tick = tick && s_q.start;
  end

  assign wrap = dir_up ? (s_q.count == gtm_pkg::COUNT_MAX) : (s_q.count == gtm_pkg::COUNT_MIN);

  // Byte-lane merge of a timer write into the reload value.
  always_comb begin
    wr_val = s_q.reload;
    if (AVS_BYTEENABLE[0]) begin
      wr_val[7:0] = AVS_WRITEDATA[7:0];
    end
    if (AVS_BYTEENABLE[1]) begin
      wr_val[15:8] = AVS_WRITEDATA[15:8];
    end
  end

  // Whole next state in one place.
  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.ovf = 1'b0;
    // Counting step.
    if (tick) begin
      if (wrap) begin
        s_d.ovf = 1'b1;
        s_d.irq = 1'b1;
        if (s_q.mode[gtm_pkg::OUT_EN_BIT]) begin
          s_d.tog = !s_q.tog;
        end
        if (is_event && s_q.mode[gtm_pkg::FREE_BIT]) begin
          s_d.count = dir_up ? gtm_pkg::COUNT_MIN : gtm_pkg::COUNT_MAX;
        end else begin
          s_d.count = s_q.reload;
        end
      end else if (dir_up) begin
        s_d.count = s_q.count + 16'h0001;
      end else begin
        s_d.count = s_q.count - 16'h0001;
      end
    end
    // Bus access: one wait cycle, then acknowledge.
    s_d.ack = access;
    if (access) begin
      s_d.rdata = 32'h0000_0000;
      if (AVS_READ) begin
        unique case (AVS_ADDRESS)
          gtm_pkg::OFS_MODE: s_d.rdata[gtm_pkg::MODE_W-1:0] = s_q.mode;
          gtm_pkg::OFS_TIMER: s_d.rdata[15:0] = s_q.count;
          gtm_pkg::OFS_START: s_d.rdata[0] = s_q.start;
          gtm_pkg::OFS_STATUS: begin
            s_d.rdata[gtm_pkg::ST_OUT_BIT] = s_q.tog;
            s_d.rdata[gtm_pkg::ST_REQ_BIT] = s_q.irq;
          end
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end else begin
        unique case (AVS_ADDRESS)
          gtm_pkg::OFS_MODE: begin
            if (AVS_BYTEENABLE[0]) begin
              s_d.mode[7:0] = AVS_WRITEDATA[7:0];
            end
            if (AVS_BYTEENABLE[1]) begin
              s_d.mode[gtm_pkg::MODE_W-1:8] = AVS_WRITEDATA[gtm_pkg::MODE_W-1:8];
            end
          end
          gtm_pkg::OFS_TIMER: begin
            s_d.reload = wr_val;
            if (!s_q.start) begin
              s_d.count = wr_val;
            end
          end
          gtm_pkg::OFS_START: begin
            if (AVS_BYTEENABLE[0]) begin
              s_d.start = AVS_WRITEDATA[0];
            end
          end
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // State register.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.mode <= gtm_pkg::MODE_RST;
      s_q.reload <= gtm_pkg::TIMER_RST;
      s_q.count <= gtm_pkg::TIMER_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops; the output pin is driven only as pulse output.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CHANNEL_TOGGLE_OUTPUT_PIN_OE <= 1'b0;
    end else begin
      CHANNEL_TOGGLE_OUTPUT_PIN_OE <= s_d.mode[gtm_pkg::OUT_EN_BIT] &&
                                      !(s_d.mode[1:0] == gtm_pkg::MODE_EVENT && s_d.mode[gtm_pkg::DIR_PIN_BIT]);
    end
  end

  assign CHANNEL_TOGGLE_OUTPUT_PIN_O = s_q.tog;
  assign IRQ_PULSE = s_q.irq;
  assign OVERFLOW_PULSE = s_q.ovf;
  assign AVS_READDATA = s_q.rdata;
  assign AVS_WAITREQUEST = !s_q.ack;

endmodule : gtm_channel

// Three-stage pin synchroniser; a level counts once the last two stages agree, so one-stage glitches drop out.
module gtm_sync3 (
  // System.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Raw pin.
  input wire logic pin,
  // Clean views of the pin.
  output logic level,
  output logic stable,
  output logic prev
);

  typedef struct packed {
    logic [2:0] sync;
    logic prev;
  } gtm_sync_s;

  gtm_sync_s s_q;
  gtm_sync_s s_d;

  // The last agreed level is kept so that an edge is seen once, not once per agreeing cycle.
  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], pin};
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.prev = s_q.sync[2];
    end
  end

  // Reset clears every stage to the low idle level.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Views of the registered stages.
  assign level = s_q.sync[2];
  assign stable = s_q.sync[1] == s_q.sync[2];
  assign prev = s_q.prev;

endmodule : gtm_sync3

// Divider stage; it reports its last count so the caller can form a one-cycle tick.
module gtm_prescale #(
  parameter logic [4:0] LAST = 5'h07
) (
  // System.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Advance and terminal count.
  input wire logic advance,
  output logic at_last
);

  // A zero ratio would tick every cycle, which is the undivided source's job, so it is refused.
  if (LAST == 5'h00) begin : g_bad_last
    $error("LAST must be nonzero");
  end

  typedef struct packed {
    logic [4:0] cnt;
  } gtm_pre_s;

  gtm_pre_s s_q;
  gtm_pre_s s_d;

  // Step the divider only on an advance; it wraps after LAST.
  always_comb begin
    s_d = s_q;
    if (advance) begin
      s_d.cnt = (s_q.cnt == LAST) ? 5'h00 : s_q.cnt + 5'h01;
    end
  end

  // Divider state.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Terminal count view.
  assign at_last = s_q.cnt == LAST;

endmodule : gtm_prescale

// ### verification/gtm_pins.sv
`timescale 1ns/10ps
// Stands in for the pulse source and the load on the channel pins.
module gtm_pins (
  // Bench control.
  input wire logic clk,
  input wire logic fire,
  input wire logic dir,
  // Channel pins.
  input wire logic o,
  input wire logic oe,
  output logic ev,
  output logic dir_pin
);
  logic [3:0] n_q = 4'h0;
  // One event is 4 cycles high, then 4 low, so the 3-stage sync sees both edges.
  always @(posedge clk) begin
    if (fire) n_q <= 4'h8;
    else if (n_q != 4'h0) n_q <= n_q - 4'h1;
  end
  assign ev = (n_q > 4'h4);
  // The pin level comes from the channel while it drives, else from the bench.
  assign dir_pin = oe ? o : dir;
endmodule : gtm_pins

// ### verification/gtm_channel_checker.sv
`timescale 1ns/10ps
module gtm_channel_checker (
  // System.
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Register bus.
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Events and pins.
  input wire logic CHANNEL_TOGGLE_OUTPUT_PIN_O,
  input wire logic IRQ_PULSE,
  input wire logic OVERFLOW_PULSE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // A request still waiting, and the one-cycle answer.
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_ack;
    !AVS_WAITREQUEST;
  endsequence
  a_wait_answer: assert property (s_req |=> s_ack) else $error("no answer");
  a_wait_single: assert property (s_ack |=> AVS_WAITREQUEST) else $error("long answer");
  a_wait_idle: assert property (!(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer without request");
  a_irq_pair: assert property (IRQ_PULSE == OVERFLOW_PULSE) else $error("pulse mismatch");
  a_out_cause: assert property ($changed(CHANNEL_TOGGLE_OUTPUT_PIN_O) |-> $past(IRQ_PULSE) or ##[0:1] IRQ_PULSE)
    else $error("toggle without underflow");
  a_hole_zero: assert property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS[1:0] != 2'h0 |-> AVS_READDATA == 32'h0)
    else $error("unmapped read");
  a_timer_upper: assert property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS == gtm_pkg::OFS_TIMER
    |-> AVS_READDATA[31:16] == 16'h0) else $error("timer upper bits");
  a_status_upper: assert property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS == gtm_pkg::OFS_STATUS
    |-> AVS_READDATA[31:2] == 30'h0) else $error("status upper bits");
endmodule : gtm_channel_checker
bind gtm_channel gtm_channel_checker chk_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .CHANNEL_TOGGLE_OUTPUT_PIN_O(CHANNEL_TOGGLE_OUTPUT_PIN_O), .IRQ_PULSE(IRQ_PULSE),
  .OVERFLOW_PULSE(OVERFLOW_PULSE));

// ### verification/general_timer_timer_and_event_modes_tb.sv
`timescale 1ns/10ps
module general_timer_timer_and_event_modes_tb;
  localparam logic [3:0] MD = gtm_pkg::OFS_MODE;
  localparam logic [3:0] TM = gtm_pkg::OFS_TIMER;
  localparam logic [3:0] GO = gtm_pkg::OFS_START;
  logic clk = 1'h0, rst_n = 1'h0, rd = 1'h0, wr = 1'h0, fire = 1'h0, dir = 1'h0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, q, rdat, r;
  logic wreq, o, oe, irq, ev, dpin;
  int miscompares = 0, compares = 0, cyc = 0, irq_cnt = 0, irq_at = 0, t0, k;
  // Free-running bench clock.
  initial forever #20 clk = ~clk;
  gtm_channel dut_u (.SYS_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(q), .AVS_WAITREQUEST(wreq),
    .SUBCLOCK_TICK(1'h0), .PEER_B_GROUP_TIMER_OVERFLOW(1'h0), .NEIGHBOUR_CHANNEL_OVERFLOW(1'h0),
    .CHANNEL_EVENT_INPUT_PIN(ev), .CHANNEL_TOGGLE_OUTPUT_PIN_I(dpin), .CHANNEL_TOGGLE_OUTPUT_PIN_O(o),
    .CHANNEL_TOGGLE_OUTPUT_PIN_OE(oe), .IRQ_PULSE(irq), .OVERFLOW_PULSE());
  gtm_pins pins_u (.clk(clk), .fire(fire), .dir(dir), .o(o), .oe(oe), .ev(ev), .dir_pin(dpin));
  // Cycle count, pulse log and the hang limit.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'h1) begin
      irq_cnt <= irq_cnt + 1;
      irq_at <= cyc;
    end
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  // The request is held until the edge that samples waitrequest low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'h0) @(posedge clk);
    rdat = q;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask : bus
  task automatic wait_irq(input int n);
    repeat (200) if (irq_cnt < n) @(posedge clk);
  endtask : wait_irq
  task automatic pulse;
    @(posedge clk);
    fire <= 1'h1;
    @(posedge clk);
    fire <= 1'h0;
    repeat (12) @(posedge clk);
  endtask : pulse
  task automatic t_reset;
    bus(1'h0, TM, 32'h0);
    check("timer", rdat, 32'h0000FFFF);
    bus(1'h0, MD, 32'h0);
    check("mode", rdat, 32'h0);
    bus(1'h0, 4'h2, 32'h0);
    check("hole", rdat, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_timer;
    bus(1'h1, TM, 32'h5);
    bus(1'h0, TM, 32'h0);
    check("load", rdat, 32'h5);
    bus(1'h1, MD, 32'h4);
    bus(1'h1, GO, 32'h1);
    wait_irq(irq_cnt + 1);
    t0 = irq_at;
    wait_irq(irq_cnt + 1);
    check("period", 32'(irq_at - t0), 32'h6);
    bus(1'h1, TM, 32'h2);
    wait_irq(irq_cnt + 2);
    t0 = irq_at;
    wait_irq(irq_cnt + 1);
    check("reload", 32'(irq_at - t0), 32'h3);
    bus(1'h1, GO, 32'h0);
    repeat (4) @(posedge clk);
    bus(1'h0, TM, 32'h0);
    r = rdat;
    bus(1'h0, TM, 32'h0);
    check("hold", rdat, r);
    bus(1'h0, gtm_pkg::OFS_STATUS, 32'h0);
    check("toggle", 32'(rdat[0]), 32'(irq_cnt[0]));
    check("oe", 32'(oe), 32'h1);
    bus(1'h1, TM, 32'h1);
    bus(1'h1, MD, 32'h44);
    bus(1'h1, GO, 32'h1);
    wait_irq(irq_cnt + 1);
    t0 = irq_at;
    wait_irq(irq_cnt + 1);
    check("div8", 32'(irq_at - t0), 32'h10);
    bus(1'h1, GO, 32'h0);
    bus(1'h1, MD, 32'h18);
    bus(1'h1, GO, 32'h1);
    bus(1'h0, TM, 32'h0);
    r = rdat;
    bus(1'h0, TM, 32'h0);
    check("gate", rdat, r);
    bus(1'h1, GO, 32'h0);
    $display("timer test done");
  endtask : t_timer
  task automatic t_event;
    bus(1'h1, TM, 32'hFFFD);
    bus(1'h1, MD, 32'h201);
    k = irq_cnt;
    bus(1'h1, GO, 32'h1);
    pulse();
    pulse();
    bus(1'h0, TM, 32'h0);
    check("up", rdat, 32'hFFFF);
    check("early", 32'(irq_cnt), 32'(k));
    pulse();
    check("ovf", 32'(irq_cnt), 32'(k + 1));
    bus(1'h0, TM, 32'h0);
    check("reup", rdat, 32'hFFFD);
    bus(1'h1, GO, 32'h0);
    bus(1'h1, TM, 32'h1);
    bus(1'h1, MD, 32'h25);
    bus(1'h1, GO, 32'h1);
    check("pinoe", 32'(oe), 32'h0);
    pulse();
    pulse();
    check("down", 32'(irq_cnt), 32'(k + 2));
    bus(1'h1, GO, 32'h0);
    bus(1'h1, TM, 32'hFFFF);
    bus(1'h1, MD, 32'h301);
    bus(1'h1, GO, 32'h1);
    pulse();
    bus(1'h0, TM, 32'h0);
    check("wrap", rdat, 32'h0);
    check("wirq", 32'(irq_cnt), 32'(k + 3));
    $display("event test done");
  endtask : t_event
  task automatic give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // Reset, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_timer();
    t_event();
    give_verdict();
  end
endmodule : general_timer_timer_and_event_modes_tb
